// [design/irq_map.svh]
// register offsets, field positions, reset values and fixed figures of the interrupt block
`ifndef IRQ_MAP_SVH
`define IRQ_MAP_SVH

// ************************************************************
// register byte offsets (bits above the decoded byte are ignored)
// ************************************************************
`define OFF_CTRL 8'h00
`define OFF_PEN0 8'h04
`define OFF_PFL0 8'h08
`define OFF_PEN1 8'h0C
`define OFF_PFL1 8'h10
`define OFF_VARIANT 8'h14
`define OFF_CORE_STAT 8'h18
`define ADDR_HI 7

// ************************************************************
// interrupt_control_status field positions
// ************************************************************
`define BIT_GIE 7
`define BIT_PGE 6
`define BIT_T0E 5
`define BIT_EXE 4
`define BIT_PCE 3
`define BIT_T0F 2
`define BIT_EXF 1
`define BIT_PCF 0

// ************************************************************
// variant register fields
// ************************************************************
`define VAR_SINGLE 0
`define VAR_EXT 1
`define VAR_PORT 2
`define VAR_RISE 3
`define VAR_W 4

// ************************************************************
// reset values and fixed figures
// ************************************************************
`define RST_CTRL 8'h00
`define RST_PREG 8'h00
`define RST_VARIANT 4'hE
`define VECTOR_ADDR 13'h0004
`define PC_W 13
`define NUM_PAIRS 2
`define NIB_W 4
`define HTRANS_NONSEQ 2'h2

`endif

// [design/irq_pkg.sv]
// types shared by the interrupt control block
package irq_pkg;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_REQ = 2'b01,
    PH_SERVICE = 2'b10
  } irq_phase_t;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [1:0][7:0] pen;
    logic [1:0][7:0] pflag;
    logic [3:0] variant;
    logic dp_wr;
    logic [7:0] dp_addr;
    logic [31:0] rdata;
    logic hready;
    logic hresp;
    logic irq_req;
    logic [12:0] vector_pc;
    logic vector_load;
    logic nop_insert;
    logic wake;
    logic out_of_reset;
    irq_phase_t phase;
  } irq_state_t;

endpackage

// [design/pin_sync.sv]
// two-stage synchroniser for pins with a change detector behind it
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level,
  output logic [W-1:0] prev
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;
  logic [W-1:0] last_ff;

  // meta_ff feeds sync_ff only; the change detector looks at sync_ff and last_ff
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= '0;
      sync_ff <= '0;
      last_ff <= '0;
    end else begin
      meta_ff <= pin;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end

  assign level = sync_ff;
  assign prev = last_ff;
endmodule // pin_sync

// [design/core_interrupt_control.sv]
// interrupt gating and vectoring for the core, with its registers on an AHB-Lite slave
`timescale 1ns/1ps
`include "irq_map.svh"

// Operation
// - global enable set lets enabled sources interrupt; clear blocks all vectoring
// - reset clears the global enable
// - return-from-interrupt sets the global enable again
// - peripheral group enable gates every peripheral flag
// - on acceptance: clear global enable, core pushes return, pc loads 0004h
// - every flag sets on its event whatever the enables say
// - an instruction clearing global enable suppresses next-cycle vectoring, inserts a no-op
// - suppressed interrupts stay pending until global enable returns
// - timer0 enable at bit 5, flag at bit 2, set on overflow
// - external pin enable at bit 4, flag at bit 1, set on pin event
// - port change enable at bit 3, flag at bit 0, set on nibble change
// - hardware only sets flags; software clears them by writing zero
// - all eight control bits read and write, reset to zero
// - request needs flag, own enable and global enable together; peripheral flags also need the group enable
// - peripheral sources use enable/flag register pairs under the group enable
// - single-peripheral variant uses bit 6 as that source's own enable
// - absent pin or port feature leaves its bit positions reserved
// - synchronous source: flag to vector execution is three instruction cycles
// - asynchronous source: latency three to three and three-quarter cycles
module core_interrupt_control
  import irq_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // event sources
  input wire logic timer0_overflow,
  input wire logic ext_pin,
  input wire logic [3:0] port_upper_nibble_pins,
  input wire logic [15:0] periph_event,
  // core sequencer
  input wire logic irq_ack,
  input wire logic return_from_irq_instr,
  input wire logic gie_clear_instr,
  input wire logic sleep_mode,
  output logic irq_req,
  output logic [12:0] vector_pc,
  output logic vector_load,
  output logic nop_insert,
  output logic wake_req
);
  import irq_pkg::*;

  irq_state_t q;
  irq_state_t d;
  logic ext_level;
  logic ext_prev;
  logic [3:0] port_level;
  logic [3:0] port_prev;

  // ************************************************************
  // helpers
  // ************************************************************
  // control bits that exist on this variant; absent features read as zero
  function automatic logic [7:0] ctrl_mask(input logic [3:0] v);
    logic [7:0] m;
    m = 8'hFF;
    if (!v[`VAR_EXT]) begin
      m[`BIT_EXE] = 1'b0;
      m[`BIT_EXF] = 1'b0;
    end
    if (!v[`VAR_PORT]) begin
      m[`BIT_PCE] = 1'b0;
      m[`BIT_PCF] = 1'b0;
    end
    return m;
  endfunction

  function automatic logic core_pending(input logic [7:0] c);
    return (c[`BIT_T0F] & c[`BIT_T0E]) | (c[`BIT_EXF] & c[`BIT_EXE])
      | (c[`BIT_PCF] & c[`BIT_PCE]);
  endfunction

  function automatic logic periph_pending(input logic [7:0] c, input logic [3:0] v,
    input logic [1:0][7:0] en, input logic [1:0][7:0] fl);
    logic hit;
    hit = 1'b0;
    if (v[`VAR_SINGLE]) begin
      hit = fl[0][0] & c[`BIT_PGE];
    end else begin
      for (int i = 0; i < `NUM_PAIRS; i++) begin
        hit = hit | (|(en[i] & fl[i]));
      end
      hit = hit & c[`BIT_PGE];
    end
    return hit;
  endfunction

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  pin_sync #(.W(1)) ext_sync (
    .clock(clock),
    .rst_n(rst_n),
    .pin(ext_pin),
    .level(ext_level),
    .prev(ext_prev)
  );

  pin_sync #(.W(`NIB_W)) port_sync (
    .clock(clock),
    .rst_n(rst_n),
    .pin(port_upper_nibble_pins),
    .level(port_level),
    .prev(port_prev)
  );

  // ************************************************************
  // next state
  // ************************************************************
  logic ext_evt;
  logic port_evt;
  logic clr_evt;
  logic rd_req;
  logic wr_req;
  logic [7:0] wv;
  logic [7:0] mask;
  logic any_pend;
  logic wake_pend;

  always_comb begin
    d = q;
    d.out_of_reset = 1'b1;
    d.hready = 1'b1;
    d.hresp = 1'b0;
    d.vector_load = 1'b0;
    d.nop_insert = 1'b0;
    mask = ctrl_mask(q.variant);
    wv = hwdata[7:0];
    // edge polarity of the external pin is a variant choice
    ext_evt = q.variant[`VAR_RISE] ? (ext_level & ~ext_prev) : (~ext_level & ext_prev);
    ext_evt = ext_evt & q.variant[`VAR_EXT];
    port_evt = (|(port_level ^ port_prev)) & q.variant[`VAR_PORT];
    rd_req = hsel & hready & (htrans == `HTRANS_NONSEQ) & ~hwrite;
    wr_req = hsel & hready & (htrans == `HTRANS_NONSEQ) & hwrite;
    clr_evt = gie_clear_instr;

    // data phase of a write
    if (q.dp_wr) begin
      case (q.dp_addr)
        `OFF_CTRL: begin
          d.ctrl = wv & mask;
          if (q.ctrl[`BIT_GIE] && !wv[`BIT_GIE]) begin
            clr_evt = 1'b1;
          end
        end
        `OFF_PEN0: d.pen[0] = wv;
        `OFF_PFL0: d.pflag[0] = wv;
        `OFF_PEN1: d.pen[1] = wv;
        `OFF_PFL1: d.pflag[1] = wv;
        `OFF_VARIANT: begin
          d.variant = wv[`VAR_W-1:0];
          d.ctrl = d.ctrl & ctrl_mask(wv[`VAR_W-1:0]);
        end
        default: begin
        end
      endcase
    end

    if (gie_clear_instr) begin
      d.ctrl[`BIT_GIE] = 1'b0;
    end
    // acceptance by the core clears the global enable; return sets it again
    if (irq_ack) begin
      d.ctrl[`BIT_GIE] = 1'b0;
      d.vector_pc = `VECTOR_ADDR;
      d.vector_load = 1'b1;
    end
    if (return_from_irq_instr) begin
      d.ctrl[`BIT_GIE] = 1'b1;
    end

    // hardware sets after software writes so a coincident event is never lost
    if (timer0_overflow) begin
      d.ctrl[`BIT_T0F] = 1'b1;
    end
    // gate with the new variant too, so a variant write cannot leave a stale flag behind
    if (ext_evt && d.variant[`VAR_EXT]) begin
      d.ctrl[`BIT_EXF] = 1'b1;
    end
    if (port_evt && d.variant[`VAR_PORT]) begin
      d.ctrl[`BIT_PCF] = 1'b1;
    end
    d.pflag[0] = d.pflag[0] | periph_event[7:0];
    d.pflag[1] = d.pflag[1] | periph_event[15:8];

    // flags are kept; only the request is held back while enables forbid it
    any_pend = core_pending(d.ctrl) | periph_pending(d.ctrl, d.variant, d.pen, d.pflag);
    d.irq_req = d.ctrl[`BIT_GIE] & any_pend & ~clr_evt;
    d.nop_insert = clr_evt;

    // wake-up ignores the global enable
    wake_pend = core_pending(q.ctrl) | periph_pending(q.ctrl, q.variant, q.pen, q.pflag);
    d.wake = sleep_mode & wake_pend;

    case (q.phase)
      PH_IDLE: begin
        if (d.irq_req) begin
          d.phase = PH_REQ;
        end
      end
      PH_REQ: begin
        if (irq_ack) begin
          d.phase = PH_SERVICE;
        end else if (!d.irq_req) begin
          d.phase = PH_IDLE;
        end
      end
      PH_SERVICE: begin
        if (return_from_irq_instr) begin
          d.phase = PH_IDLE;
        end
      end
      default: d.phase = PH_IDLE;
    endcase

    // address phase capture and read data for the following data phase
    d.dp_wr = wr_req;
    d.dp_addr = haddr[`ADDR_HI:0];
    d.rdata = '0;
    if (rd_req) begin
      case (haddr[`ADDR_HI:0])
        `OFF_CTRL: d.rdata[7:0] = q.ctrl;
        `OFF_PEN0: d.rdata[7:0] = q.pen[0];
        `OFF_PFL0: d.rdata[7:0] = q.pflag[0];
        `OFF_PEN1: d.rdata[7:0] = q.pen[1];
        `OFF_PFL1: d.rdata[7:0] = q.pflag[1];
        `OFF_VARIANT: d.rdata[`VAR_W-1:0] = q.variant;
        `OFF_CORE_STAT: d.rdata[4:0] = {q.wake, q.nop_insert, q.irq_req, q.phase};
        default: d.rdata = '0;
      endcase
    end
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      q.ctrl <= `RST_CTRL;
      q.pen <= {`RST_PREG, `RST_PREG};
      q.pflag <= {`RST_PREG, `RST_PREG};
      q.variant <= `RST_VARIANT;
      q.dp_wr <= 1'b0;
      q.dp_addr <= '0;
      q.rdata <= '0;
      q.hready <= 1'b1;
      q.hresp <= 1'b0;
      q.irq_req <= 1'b0;
      q.vector_pc <= '0;
      q.vector_load <= 1'b0;
      q.nop_insert <= 1'b0;
      q.wake <= 1'b0;
      q.out_of_reset <= 1'b0;
      q.phase <= PH_IDLE;
    end else begin
      q <= d;
    end
  end

  assign hreadyout = q.hready;
  assign hresp = q.hresp;
  assign hrdata = q.rdata;
  assign irq_req = q.irq_req;
  assign vector_pc = q.vector_pc;
  assign vector_load = q.vector_load;
  assign nop_insert = q.nop_insert;
  assign wake_req = q.wake;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  gie_blocks_a: assert property (irq_req |-> q.ctrl[`BIT_GIE])
    else $error("request raised with global enable clear");
  reset_clear_a: assert property (!q.out_of_reset |-> q.ctrl == `RST_CTRL && !irq_req)
    else $error("control register not cleared by reset");
  return_from_irq_instr_sets_a: assert property (return_from_irq_instr |=> q.ctrl[`BIT_GIE])
    else $error("return did not set global enable");
  periph_gate_a: assert property (irq_req && !core_pending(q.ctrl) |-> q.ctrl[`BIT_PGE])
    else $error("peripheral request passed closed group enable");
  ack_vector_a: assert property (irq_ack && !return_from_irq_instr
    |=> !q.ctrl[`BIT_GIE] && vector_load && vector_pc == `VECTOR_ADDR)
    else $error("acceptance did not vector");
  t0_flag_a: assert property (timer0_overflow |=> q.ctrl[`BIT_T0F])
    else $error("timer0 flag not set");
  clear_nop_a: assert property (gie_clear_instr |=> nop_insert && !irq_req ##1 !irq_req)
    else $error("no-op or suppression missing");
  pend_kept_a: assert property (gie_clear_instr && q.ctrl[`BIT_T0F] && !q.dp_wr
    |=> q.ctrl[`BIT_T0F])
    else $error("suppressed flag lost");
  req_latency_a: assert property (q.ctrl[`BIT_GIE] && q.ctrl[`BIT_T0E] && q.ctrl[`BIT_T0F]
    && !q.dp_wr && !gie_clear_instr && !irq_ack |=> irq_req)
    else $error("request late");
  wake_a: assert property (sleep_mode && q.ctrl[`BIT_EXE] && q.ctrl[`BIT_EXF] |=> wake_req)
    else $error("wake-up missing");
  ext_flag_a: assert property (ext_level && !ext_prev && q.variant[`VAR_RISE]
    && q.variant[`VAR_EXT] && !q.dp_wr |=> q.ctrl[`BIT_EXF])
    else $error("external pin flag not set");
  port_flag_a: assert property ((port_level != port_prev) && q.variant[`VAR_PORT]
    && !q.dp_wr |=> q.ctrl[`BIT_PCF])
    else $error("port change flag not set");
  flag_sticky_a: assert property (q.ctrl[`BIT_T0F] && !q.dp_wr |=> q.ctrl[`BIT_T0F])
    else $error("hardware cleared a flag");
  absent_bits_a: assert property (!q.variant[`VAR_EXT] |-> !q.ctrl[`BIT_EXE] && !q.ctrl[`BIT_EXF])
    else $error("absent feature bits not reserved");
  ext_latency_a: assert property (ext_level && !ext_prev && q.variant[`VAR_RISE]
    && q.variant[`VAR_EXT] && q.ctrl[`BIT_GIE] && q.ctrl[`BIT_EXE] && !q.dp_wr
    && !gie_clear_instr && !irq_ack |=> irq_req)
    else $error("external request late");
  vector_once_a: assert property (vector_load |-> $past(irq_ack))
    else $error("vector load without acceptance");
  req_source_a: assert property (irq_req |-> core_pending(q.ctrl)
    | periph_pending(q.ctrl, q.variant, q.pen, q.pflag))
    else $error("request without enabled flag");

  // ************************************************************
  // covers
  // ************************************************************
  accept_c: cover property (irq_req ##[1:8] irq_ack ##[1:20] return_from_irq_instr);
  suppress_c: cover property (gie_clear_instr && q.ctrl[`BIT_T0F]);
  wake_c: cover property (wake_req);
  single_c: cover property (q.variant[`VAR_SINGLE] && irq_req);
endmodule // core_interrupt_control

// [dv/core_seq_model.sv]
// core sequencer model: takes requests, records vector loads, returns later
`timescale 1ns/1ps
module core_seq_model (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic irq_req,
  input wire logic vector_load,
  input wire logic [12:0] vector_pc,
  input wire logic auto_en,
  input wire logic [7:0] ret_delay,
  output logic irq_ack,
  output logic return_from_irq_instr,
  output logic [12:0] last_pc,
  output int n_taken
);
  logic busy;
  logic [7:0] cnt;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_ack <= 1'b0;
      return_from_irq_instr <= 1'b0;
      last_pc <= 13'h0000;
      n_taken <= 0;
      busy <= 1'b0;
      cnt <= 8'h00;
    end else begin
      // one ack per request, never while a routine is running
      irq_ack <= auto_en && irq_req && !busy && !irq_ack;
      return_from_irq_instr <= 1'b0;
      if (irq_ack) begin
        busy <= 1'b1;
      end
      if (vector_load) begin
        last_pc <= vector_pc;
        n_taken <= n_taken + 1;
        cnt <= ret_delay;
      end else if (busy && cnt != 8'h00) begin
        cnt <= cnt - 8'h01;
      end else if (busy && !irq_ack) begin
        return_from_irq_instr <= 1'b1;
        busy <= 1'b0;
      end
    end
  end
endmodule // core_seq_model

// [dv/core_interrupt_control_bench.sv]
// self-checking bench for the interrupt control block
`timescale 1ns/1ps
`include "irq_map.svh"
module core_interrupt_control_bench;
  import irq_pkg::*;
  logic clock, rst_n, hsel, hwrite, hreadyout, hresp, timer0_overflow, ext_pin;
  logic irq_ack, return_from_irq_instr, gie_clear_instr, sleep_mode, irq_req;
  logic vector_load, nop_insert, wake_req, auto_en;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [3:0] port_upper_nibble_pins;
  logic [15:0] periph_event;
  logic [12:0] vector_pc, last_pc;
  int n_taken, n_mismatch, tests_run;

  core_interrupt_control core_interrupt_control_inst (.clock, .rst_n, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
    .timer0_overflow, .ext_pin, .port_upper_nibble_pins, .periph_event, .irq_ack,
    .return_from_irq_instr, .gie_clear_instr, .sleep_mode, .irq_req, .vector_pc,
    .vector_load, .nop_insert, .wake_req);
  core_seq_model core_seq_model_inst (.clock, .rst_n, .irq_req, .vector_load, .vector_pc,
    .auto_en, .ret_delay(8'h20), .irq_ack, .return_from_irq_instr, .last_pc, .n_taken);

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // ****************
  // bus and checks
  // ****************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    haddr <= {24'h000000, a};
    htrans <= `HTRANS_NONSEQ;
    hwrite <= w;
    hsel <= 1'b1;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h00000000);
    chk(nm, rd, exp);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    #40000;
    n_mismatch++;
    print_verdict;
  end

  initial begin
    {hsel, hwrite, timer0_overflow, ext_pin, gie_clear_instr, sleep_mode, auto_en} = '0;
    htrans = 2'h0;
    hsize = 3'h2;
    haddr = '0;
    hwdata = '0;
    port_upper_nibble_pins = 4'h0;
    periph_event = 16'h0000;
    rst_n = 1'b0;
    tick(16);
    rst_n <= 1'b1;
    tick(1);
    rchk("ctrl reset", `OFF_CTRL, 32'h0);
    rchk("pen0 reset", `OFF_PEN0, 32'h0);
    rchk("unmapped", 8'h1C, 32'h0);
    chk("hresp", hresp, 32'h0);
    bus(`OFF_CTRL, 1'b1, 32'hFF);
    rchk("ctrl rw", `OFF_CTRL, 32'hFF);
    bus(`OFF_CTRL, 1'b1, 32'h00);
    timer0_overflow <= 1'b1;
    tick(1);
    timer0_overflow <= 1'b0;
    tick(2);
    chk("irq no gie", irq_req, 32'h0);
    rchk("t0 flag", `OFF_CTRL, 32'h04);
    bus(`OFF_CTRL, 1'b1, 32'h00);
    rchk("flag clear", `OFF_CTRL, 32'h00);
    $display("test access and flags done");
    bus(`OFF_CTRL, 1'b1, 32'hA0);
    timer0_overflow <= 1'b1;
    tick(1);
    timer0_overflow <= 1'b0;
    tick(2);
    chk("irq latency", irq_req, 32'h1);
    gie_clear_instr <= 1'b1;
    tick(1);
    gie_clear_instr <= 1'b0;
    tick(1);
    chk("nop", nop_insert, 32'h1);
    chk("irq suppressed", irq_req, 32'h0);
    rchk("pending", `OFF_CTRL, 32'h24);
    auto_en <= 1'b1;
    bus(`OFF_CTRL, 1'b1, 32'hA4);
    for (int i = 0; i < 20 && n_taken == 0; i++) tick(1);
    chk("taken", n_taken, 32'h1);
    chk("vector", last_pc, 32'h4);
    rchk("gie off", `OFF_CTRL, 32'h24);
    for (int i = 0; i < 80 && n_taken == 1; i++) tick(1);
    chk("retaken", n_taken, 32'h2);
    auto_en <= 1'b0;
    bus(`OFF_CTRL, 1'b1, 32'h00);
    tick(40);
    $display("test vectoring done");
    bus(`OFF_CTRL, 1'b1, 32'h80);
    bus(`OFF_PEN0, 1'b1, 32'h01);
    bus(`OFF_PEN1, 1'b1, 32'h01);
    sleep_mode <= 1'b1;
    periph_event <= 16'h0101;
    tick(1);
    periph_event <= 16'h0000;
    rchk("pfl0", `OFF_PFL0, 32'h01);
    rchk("pfl1", `OFF_PFL1, 32'h01);
    chk("irq group off", irq_req, 32'h0);
    chk("wake group off", wake_req, 32'h0);
    bus(`OFF_CTRL, 1'b1, 32'h40);
    tick(2);
    chk("irq no gie", irq_req, 32'h0);
    chk("wake", wake_req, 32'h1);
    bus(`OFF_CTRL, 1'b1, 32'hC0);
    tick(2);
    chk("irq periph", irq_req, 32'h1);
    bus(`OFF_PFL0, 1'b1, 32'h00);
    bus(`OFF_PFL1, 1'b1, 32'h00);
    tick(2);
    chk("irq cleared", irq_req, 32'h0);
    $display("test peripherals done");
    bus(`OFF_PEN0, 1'b1, 32'h00);
    bus(`OFF_VARIANT, 1'b1, 32'h01);
    bus(`OFF_CTRL, 1'b1, 32'hFF);
    rchk("absent bits", `OFF_CTRL, 32'hE4);
    bus(`OFF_CTRL, 1'b1, 32'hC0);
    periph_event <= 16'h0001;
    tick(1);
    periph_event <= 16'h0000;
    tick(2);
    chk("irq single", irq_req, 32'h1);
    bus(`OFF_PFL0, 1'b1, 32'h00);
    bus(`OFF_CTRL, 1'b1, 32'h00);
    bus(`OFF_VARIANT, 1'b1, 32'h0E);
    $display("test variant done");
    bus(`OFF_CTRL, 1'b1, 32'h00);
    ext_pin <= 1'b1;
    tick(6);
    rchk("ext flag", `OFF_CTRL, 32'h02);
    port_upper_nibble_pins <= 4'h8;
    tick(6);
    rchk("port flag", `OFF_CTRL, 32'h03);
    ext_pin <= 1'b0;
    port_upper_nibble_pins <= 4'h0;
    tick(6);
    bus(`OFF_CTRL, 1'b1, 32'hB8);
    rst_n <= 1'b0;
    tick(2);
    rst_n <= 1'b1;
    tick(1);
    rchk("ctrl second reset", `OFF_CTRL, 32'h00);
    $display("test pins and reset done");
    print_verdict;
  end
endmodule // core_interrupt_control_bench
